// *** hw/ssq_pkg.sv ***
// Constants and types shared by the smoke test and mode sequencer
package ssq_pkg;

	localparam int  CLK_PERIOD_NS     = 8;
	// Internal oscillator period and its length in system clocks
	localparam real OSC_PERIOD_MS     = 10.5;
	localparam int  OSC_TICK_CYC      = $rtoi(OSC_PERIOD_MS * 1.0e6 / CLK_PERIOD_NS);
	// Emitter pulse width
	localparam int  IR_WIDTH_US       = 105;
	localparam int  IR_WIDTH_CYC      = IR_WIDTH_US * 1000 / CLK_PERIOD_NS;
	// Emitter pacing during the push-button test, in oscillator cycles
	localparam real TEST_PACE_MS      = 336.0;
	localparam int  TEST_PACE_TICKS   = $rtoi(TEST_PACE_MS / OSC_PERIOD_MS);
	// Standby smoke test pacing and the slot of the supply check in it
	localparam int  STBY_PACE_TICKS   = 32;
	localparam int  LS_SLOT_TICK      = 16;
	localparam int  PACE_W            = 6;
	// Pulses before the test verdict and before leaving the alarm
	localparam int  TEST_DECIDE_PULSES = 2;
	localparam int  REL_EXIT_PULSES   = 2;
	localparam int  PULSE_CNT_W       = 2;

	// Reset values of the pin drivers
	localparam logic RST_IND_OE       = 1'b0;
	localparam logic RST_STROBE_N     = 1'b1;

	typedef enum logic [1:0] {
		SSQ_M_STANDBY = 2'b00,
		SSQ_M_TEST    = 2'b01,
		SSQ_M_RELEASE = 2'b11,
		SSQ_M_CAL     = 2'b10
	} ssq_mode_e;

	typedef enum logic [1:0] {
		SSQ_E_IDLE  = 2'b00,
		SSQ_E_BLANK = 2'b01,
		SSQ_E_FIRE  = 2'b11,
		SSQ_E_TAIL  = 2'b10
	} ssq_emit_e;

	// Pin-level inputs, all asynchronous to clk
	typedef struct packed {
		logic test_high;
		logic cal_pull;
		logic test_float;
		logic smoke;
		logic io_line;
	} ssq_pin_in_s;

	localparam int PIN_IN_W = $bits(ssq_pin_in_s);

endpackage : ssq_pkg

// *** hw/ssq_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
module ssq_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_ff  <= '0;
			sync_out <= '0;
		end else begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule : ssq_sync

// *** hw/ssq_sequencer.sv ***
// Smoke detector indicator, push-button test and calibration sequencer
`timescale 1ns/1ps
module ssq_sequencer
	import ssq_pkg::*;
#(
	parameter int OSC_TICK_CYC_P = ssq_pkg::OSC_TICK_CYC,
	parameter int IR_WIDTH_CYC_P = ssq_pkg::IR_WIDTH_CYC
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire ssq_pkg::ssq_pin_in_s pins_in,
	output logic                     status_indicator_out,
	output logic                     status_indicator_oe,
	output logic                     ir_emitter_drive,
	output logic                     high_gain_capacitor,
	output logic                     strobe_n,
	output logic                     horn_drive,
	output logic                     io_line_out,
	output logic                     io_line_oe,
	output logic                     low_supply_load
);
	import ssq_pkg::*;

	localparam int TICK_W = $clog2(OSC_TICK_CYC_P + 1);
	localparam int IR_W   = $clog2(IR_WIDTH_CYC_P + 1);

	ssq_pin_in_s             pins_s;
	logic [TICK_W-1:0]       tick_cnt_ff;
	logic                    osc_tick;
	ssq_mode_e               mode_ff;
	ssq_emit_e               emit_ff;
	ssq_emit_e               nxt_emit;
	logic [IR_W-1:0]         ir_cnt_ff;
	logic [PACE_W-1:0]       pace_cnt_ff;
	logic [PULSE_CNT_W-1:0]  pulse_cnt_ff;
	logic                    emit_req;
	logic                    res_valid;
	logic                    local_smoke_ff;
	logic                    remote_ff;
	logic                    test_alarm_ff;
	logic                    test_fail_ff;
	logic                    alarm;
	logic                    ind_want;
	logic                    horn_want;

	// Pull-down is analog; an open pin reads low here
	ssq_sync #(
		.WIDTH    (PIN_IN_W)
	) u_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in (pins_in),
		.sync_out (pins_s)
	);

	// Oscillator cycle stand-in derived from the system clock
	assign osc_tick = (tick_cnt_ff == TICK_W'(OSC_TICK_CYC_P - 1));

	always_ff @(posedge clk) begin
		if (sys_rst || osc_tick) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
		end
	end

	// Emitter requests per mode
	always_comb begin
		emit_req = 1'b0;
		if (osc_tick) begin
			unique case (mode_ff)
				SSQ_M_CAL:     emit_req = 1'b1;
				SSQ_M_STANDBY: emit_req = (pace_cnt_ff == '0);
				SSQ_M_TEST,
				SSQ_M_RELEASE: emit_req = (pace_cnt_ff == '0);
			endcase
		end
	end

	// Blank, fire, tail: indicator, horn and supply load go quiet one clock before and after the pulse
	always_comb begin
		nxt_emit = emit_ff;
		unique case (emit_ff)
			SSQ_E_IDLE:  if (emit_req) nxt_emit = SSQ_E_BLANK;
			SSQ_E_BLANK: nxt_emit = SSQ_E_FIRE;
			SSQ_E_FIRE:  if (ir_cnt_ff == IR_W'(IR_WIDTH_CYC_P - 1)) nxt_emit = SSQ_E_TAIL;
			SSQ_E_TAIL:  nxt_emit = SSQ_E_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			emit_ff <= SSQ_E_IDLE;
		end else begin
			emit_ff <= nxt_emit;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || emit_ff != SSQ_E_FIRE) begin
			ir_cnt_ff <= '0;
		end else begin
			ir_cnt_ff <= ir_cnt_ff + IR_W'(1);
		end
	end

	// Smoke comparator is read at the end of the pulse
	assign res_valid = (emit_ff == SSQ_E_FIRE) && (nxt_emit == SSQ_E_TAIL);

	// Mode sequencing
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_ff <= SSQ_M_STANDBY;
		end else if (osc_tick && mode_ff != SSQ_M_CAL && pins_s.cal_pull) begin
			mode_ff <= SSQ_M_CAL;
		end else if (osc_tick) begin
			unique case (mode_ff)
				SSQ_M_STANDBY: if (pins_s.test_high) mode_ff <= SSQ_M_TEST;
				SSQ_M_TEST:    if (!pins_s.test_high) mode_ff <= SSQ_M_RELEASE;
				SSQ_M_RELEASE: if (pins_s.test_high) mode_ff <= SSQ_M_TEST;
				SSQ_M_CAL:     if (pins_s.test_float) mode_ff <= SSQ_M_STANDBY;
			endcase
		end else if (mode_ff == SSQ_M_RELEASE && res_valid &&
			pulse_cnt_ff == PULSE_CNT_W'(REL_EXIT_PULSES - 1)) begin
			mode_ff <= SSQ_M_STANDBY;
		end
	end

	// Pace counter restarts on entry to test from standby and on entry to release, so the first test pulse
	// lands one oscillator cycle after the button is seen
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pace_cnt_ff <= '0;
		end else if (osc_tick) begin
			if ((mode_ff == SSQ_M_STANDBY && pins_s.test_high) ||
				(mode_ff == SSQ_M_TEST && !pins_s.test_high)) begin
				pace_cnt_ff <= '0;
			end else if (mode_ff == SSQ_M_STANDBY) begin
				pace_cnt_ff <= (pace_cnt_ff == PACE_W'(STBY_PACE_TICKS - 1)) ?
					'0 : pace_cnt_ff + PACE_W'(1);
			end else begin
				pace_cnt_ff <= (pace_cnt_ff == PACE_W'(TEST_PACE_TICKS - 1)) ?
					'0 : pace_cnt_ff + PACE_W'(1);
			end
		end
	end

	// Pulses counted since entering test or release
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pulse_cnt_ff <= '0;
		end else if (osc_tick && ((mode_ff != SSQ_M_TEST && pins_s.test_high) ||
			(mode_ff == SSQ_M_TEST && !pins_s.test_high))) begin
			pulse_cnt_ff <= '0;
		end else if (res_valid && pulse_cnt_ff != '1) begin
			pulse_cnt_ff <= pulse_cnt_ff + PULSE_CNT_W'(1);
		end
	end

	// Test verdict after the second pulse
	always_ff @(posedge clk) begin
		if (sys_rst || mode_ff == SSQ_M_STANDBY || mode_ff == SSQ_M_CAL) begin
			test_alarm_ff <= 1'b0;
			test_fail_ff  <= 1'b0;
		end else if (mode_ff == SSQ_M_TEST && res_valid &&
			pulse_cnt_ff == PULSE_CNT_W'(TEST_DECIDE_PULSES - 1)) begin
			test_alarm_ff <= pins_s.smoke;
			test_fail_ff  <= !pins_s.smoke;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || mode_ff != SSQ_M_STANDBY) begin
			local_smoke_ff <= 1'b0;
		end else if (res_valid) begin
			local_smoke_ff <= pins_s.smoke;
		end
	end

	// Our own drive would read back as remote smoke, so it is masked
	always_ff @(posedge clk) begin
		if (sys_rst || mode_ff == SSQ_M_CAL) begin
			remote_ff <= 1'b0;
		end else if (osc_tick && !io_line_oe) begin
			remote_ff <= pins_s.io_line;
		end
	end

	assign alarm = local_smoke_ff || remote_ff || test_alarm_ff;

	always_comb begin
		unique case (mode_ff)
			SSQ_M_STANDBY: ind_want = !local_smoke_ff;
			SSQ_M_TEST,
			SSQ_M_RELEASE: ind_want = test_fail_ff;
			SSQ_M_CAL:     ind_want = 1'b1;
		endcase
	end

	assign horn_want = alarm && (mode_ff != SSQ_M_CAL);

	// Pin drivers; indicator and horn drop for the whole pulse plus one clock either side,
	// about 105 us, far too short to be seen or heard
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_indicator_out <= 1'b0;
			status_indicator_oe  <= RST_IND_OE;
			horn_drive           <= 1'b0;
		end else begin
			status_indicator_out <= 1'b0;
			status_indicator_oe  <= ind_want && (nxt_emit == SSQ_E_IDLE);
			horn_drive           <= horn_want && (nxt_emit == SSQ_E_IDLE);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ir_emitter_drive <= 1'b0;
		end else begin
			ir_emitter_drive <= (nxt_emit == SSQ_E_FIRE);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			strobe_n <= RST_STROBE_N;
		end else begin
			strobe_n <= !((mode_ff == SSQ_M_CAL) || (nxt_emit != SSQ_E_IDLE));
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			high_gain_capacitor <= 1'b0;
		end else begin
			high_gain_capacitor <= (mode_ff == SSQ_M_TEST);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			io_line_out <= 1'b0;
			io_line_oe  <= 1'b0;
		end else begin
			io_line_out <= 1'b1;
			io_line_oe  <= (local_smoke_ff || test_alarm_ff) && (mode_ff != SSQ_M_CAL);
		end
	end

	// Supply load sits mid-way between standby smoke tests
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			low_supply_load <= 1'b0;
		end else begin
			low_supply_load <= (mode_ff == SSQ_M_STANDBY) && !alarm &&
				(pace_cnt_ff == PACE_W'(LS_SLOT_TICK)) && (nxt_emit == SSQ_E_IDLE);
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic [IR_W:0] ir_hi_cnt_ff;
	always_ff @(posedge clk) begin
		if (sys_rst || !ir_emitter_drive) begin
			ir_hi_cnt_ff <= '0;
		end else begin
			ir_hi_cnt_ff <= ir_hi_cnt_ff + (IR_W+1)'(1);
		end
	end

	ir_width_a: assert property ($fell(ir_emitter_drive) |->
		$past(ir_hi_cnt_ff) == (IR_W+1)'(IR_WIDTH_CYC_P - 1))
		else $error("emitter pulse width wrong");
	ir_quiet_a: assert property (ir_emitter_drive |->
		!status_indicator_oe && !horn_drive && $past(!status_indicator_oe))
		else $error("emitter pulse overlaps indicator or horn");
	cal_strobe_a: assert property ($past(mode_ff) == SSQ_M_CAL |-> !strobe_n)
		else $error("strobe not low in calibration");
	cal_pulse_a: assert property (mode_ff == SSQ_M_CAL && osc_tick &&
		emit_ff == SSQ_E_IDLE |-> ##2 ir_emitter_drive)
		else $error("calibration cycle without emitter pulse");
	test_gain_a: assert property ($past(mode_ff) == SSQ_M_TEST |-> high_gain_capacitor)
		else $error("high gain missing in test");
	rel_gain_a: assert property (mode_ff == SSQ_M_RELEASE ##1 1'b1 |->
		!high_gain_capacitor)
		else $error("high gain kept after release");
	ls_excl_a: assert property (low_supply_load |->
		$past(mode_ff) == SSQ_M_STANDBY && !ir_emitter_drive && !horn_drive)
		else $error("supply load coincides with activity");
	io_ignore_a: assert property ($rose(remote_ff) |-> !$past(io_line_oe))
		else $error("interconnect read while sourcing");
	smoke_dark_a: assert property ($past(local_smoke_ff) &&
		$past(mode_ff) == SSQ_M_STANDBY |-> !status_indicator_oe)
		else $error("indicator lit during local smoke");
	od_low_a: assert property (status_indicator_oe |-> !status_indicator_out)
		else $error("indicator driven high");
endmodule : ssq_sequencer

// *** bench/ssq_far_model.sv ***
// Far-side model: push button, test pin states, chamber smoke and remote units
`timescale 1ns/1ps
module ssq_far_model
	import ssq_pkg::*;
(
	input  wire logic            btn_press,
	input  wire logic            cal_pull,
	input  wire logic            pin_float,
	input  wire logic            smoke,
	input  wire logic            remote_drive,
	input  wire logic            io_line_oe,
	output ssq_pkg::ssq_pin_in_s pins
);
	// Pull-down keeps the pin low unless the switch closes to supply
	assign pins.test_high  = btn_press & ~cal_pull & ~pin_float;
	assign pins.cal_pull   = cal_pull;
	assign pins.test_float = pin_float;
	assign pins.smoke      = smoke;
	// Wired-OR with sink: high whenever any unit sources
	assign pins.io_line    = io_line_oe | remote_drive;
endmodule : ssq_far_model

// *** bench/smoke_test_mode_sequencer_tb.sv ***
// Self-checking bench for the smoke test and mode sequencer
`timescale 1ns/1ps
module smoke_test_mode_sequencer_tb;
	import ssq_pkg::*;
	// Short oscillator keeps the run small; the tick-based delays below scale with it, the 90000-clock timeout does not
	localparam int OSC = 100;
	localparam int IRW = 10;
	localparam int TK  = OSC * 8;
	logic        clk, sys_rst, btn, cal, flt, smk, rmt;
	ssq_pin_in_s pins;
	logic        ind, ind_oe, ir, hg, strb_n, horn, io_o, io_oe, ls_load;
	int          err_count, checks;

	ssq_sequencer #(.OSC_TICK_CYC_P(OSC), .IR_WIDTH_CYC_P(IRW)) dut (
		.clk(clk), .sys_rst(sys_rst), .pins_in(pins), .status_indicator_out(ind),
		.status_indicator_oe(ind_oe), .ir_emitter_drive(ir), .high_gain_capacitor(hg),
		.strobe_n(strb_n), .horn_drive(horn), .io_line_out(io_o), .io_line_oe(io_oe),
		.low_supply_load(ls_load));
	ssq_far_model far (.btn_press(btn), .cal_pull(cal), .pin_float(flt), .smoke(smk),
		.remote_drive(rmt), .io_line_oe(io_oe), .pins(pins));

	initial clk = 1'b0;
	always #4 clk = ~clk;

	task automatic give_verdict;
		if (err_count == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask : chk

	task automatic ticks(input int n);
		repeat (n * OSC) @(negedge clk);
	endtask : ticks

	task automatic get_pulse(output time t_rise, output int w);
		int n;
		n = 0;
		w = 0;
		while (ir !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 40 * OSC) begin
				err_count++;
				$display("ERROR %0t no emitter pulse", $time);
				give_verdict();
			end
		end
		t_rise = $time;
		while (ir === 1'b1 && w <= IRW) begin
			@(negedge clk);
			w++;
		end
	endtask : get_pulse

	task automatic wait_hg(input logic lvl);
		int n;
		n = 0;
		while (hg !== lvl) begin
			@(negedge clk);
			n++;
			if (n > 3 * OSC) begin
				err_count++;
				$display("ERROR %0t gain select stuck", $time);
				give_verdict();
			end
		end
	endtask : wait_hg

	// Pin checks that must hold on every cycle out of reset
	always @(negedge clk) begin
		if (!sys_rst) begin
			checks++;
			if (ind !== 1'b0 ||
				(ir === 1'b1 && (ind_oe !== 1'b0 || horn !== 1'b0)) ||
				(ls_load === 1'b1 && (ir | horn | hg | io_oe) !== 1'b0)) begin
				err_count++;
				$display("ERROR %0t pin conflict", $time);
			end
		end
	end

	task automatic sc_standby;
		int  w;
		time t1, t2;
		ticks(3);
		chk(ind_oe === 1'b1, "standby indicator");
		get_pulse(t1, w);
		chk(w == IRW, "pulse width");
		ticks(15);
		chk(ls_load === 1'b1, "supply load slot");
		get_pulse(t2, w);
		chk(t2 - t1 == 32 * TK, "standby pace");
	endtask : sc_standby

	task automatic sc_smoke;
		int  w;
		time t1;
		smk = 1'b1;
		get_pulse(t1, w);
		ticks(1);
		chk(ind_oe === 1'b0, "local smoke indicator");
		smk = 1'b0;
		get_pulse(t1, w);
		ticks(1);
		chk(ind_oe === 1'b1, "smoke cleared");
		rmt = 1'b1;
		ticks(3);
		chk(ind_oe === 1'b1, "remote smoke indicator");
		rmt = 1'b0;
		ticks(2);
	endtask : sc_smoke

	task automatic sc_test(input logic ok);
		int  w;
		time t0, t1, t2;
		btn = 1'b1;
		wait_hg(1'b1);
		// Smoke only after entry, so no standby pulse can latch local smoke first
		smk = ok;
		t0 = $time;
		get_pulse(t1, w);
		chk(t1 - t0 >= TK - 40 && t1 - t0 <= TK + 40, "first test pulse");
		get_pulse(t2, w);
		chk(t2 - t1 == 32 * TK, "test pace");
		ticks(1);
		chk(ok ? (horn === 1'b1 && io_oe === 1'b1 && io_o === 1'b1 && ind_oe === 1'b0)
			: (horn === 1'b0 && ind_oe === 1'b1), "test verdict");
		rmt = 1'b1;
		ticks(2);
		if (ok) chk(dut.remote_ff === 1'b0 && ind_oe === 1'b0, "line input not ignored");
		btn = 1'b0;
		rmt = 1'b0;
		smk = 1'b0;
		wait_hg(1'b0);
		get_pulse(t1, w);
		get_pulse(t2, w);
		ticks(1);
		chk(horn === 1'b0 && io_oe === 1'b0 && ind_oe === 1'b1, "alarm exit");
	endtask : sc_test

	task automatic sc_cal;
		int  w;
		time t1, t2;
		cal = 1'b1;
		ticks(2);
		cal = 1'b0;
		get_pulse(t1, w);
		get_pulse(t2, w);
		chk(t2 - t1 == TK, "calibration rate");
		chk(strb_n === 1'b0, "calibration strobe");
		flt = 1'b1;
		ticks(2);
		flt = 1'b0;
		ticks(3);
		// Half a tick off the pulse phase, so a standby pulse cannot blank the check
		repeat (OSC / 2) @(negedge clk);
		chk(strb_n === 1'b1 && ind_oe === 1'b1, "calibration exit");
	endtask : sc_cal

	initial begin
		{btn, cal, flt, smk, rmt} = '0;
		sys_rst   = 1'b1;
		err_count = 0;
		checks    = 0;
		repeat (2) @(negedge clk);
		chk(strb_n === 1'b1 && ir === 1'b0 && horn === 1'b0 && ind_oe === 1'b0, "reset");
		sys_rst = 1'b0;
		sc_standby();
		sc_smoke();
		sc_test(1'b1);
		sc_test(1'b0);
		sc_cal();
		give_verdict();
	end

	initial begin
		repeat (90000) @(posedge clk);
		err_count++;
		$display("ERROR %0t run timed out", $time);
		give_verdict();
	end
endmodule : smoke_test_mode_sequencer_tb
